// *** core/spmc_params.svh ***
// Operation
// - Hold chip reset until all supplies good
// - Power-on reset needs no external reset; the code starts from the rst_b_i input
// - Supply drop resets until all restored
// - Watchdog is 16-bit, one-millisecond ticks
// - Software programs timeout from 1 ms
// - Watchdog expiry issues full chip reset
// - Readable flag shows last reset was watchdog
// - Watchdog counts only in running state
// - Sleep and run states with transitions
// - Control register write starts sleep entry
// - Pin event or timer starts wakeup
// - Wake stimulus acted on only asleep
// - Wake during sleep entry is remembered
// - Sleep powers down core until wake
// - Pin wake on chosen level change
// - Small always-powered memory kept through sleep
// - Counter match with programmed value wakes
// - Supply loss in transition resets system
`ifndef SPMC_PARAMS_SVH
`define SPMC_PARAMS_SVH
// Register offsets
`define SPMC_A_CTRL 8'h00
`define SPMC_A_STAT 8'h04
`define SPMC_A_WDT_TO 8'h08
`define SPMC_A_WDT_KICK 8'h0C
`define SPMC_A_WAKE_CFG 8'h10
`define SPMC_A_CMP_LO 8'h14
`define SPMC_A_CMP_HI 8'h18
`define SPMC_A_CNT_LO 8'h1C
`define SPMC_A_CNT_HI 8'h20
`define SPMC_A_RSTCAUSE 8'h24
`define SPMC_A_MEM_BASE 8'h80
// Field positions
`define SPMC_CTRL_SLEEP 0
`define SPMC_CTRL_WDT_EN 1
`define SPMC_WCFG_PIN_EN 0
`define SPMC_WCFG_PIN_POL 1
`define SPMC_WCFG_TMR_EN 2
`define SPMC_RC_WDT 0
`define SPMC_RC_POR 1
// Reset values and timing
`define SPMC_WDT_TO_RST 16'hFFFF
`define SPMC_TICK_NS 1_000_000
`define SPMC_CLK_NS 8
`define SPMC_STEP_CYC 16
`endif

// *** core/spmc_pkg.sv ***
package spmc_pkg;
  typedef enum logic [2:0] {
    SPMC_PWRUP, SPMC_AWAKE, SPMC_GO_SLEEP, SPMC_ASLEEP, SPMC_GO_WAKE
  } spmc_state_t;
endpackage

// *** core/spmc_wdt.sv ***
`timescale 1ns/100ps
`include "spmc_params.svh"
module spmc_wdt #(
  parameter int TICK_CYC = `SPMC_TICK_NS / `SPMC_CLK_NS
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Control
  input wire logic run_i,
  input wire logic kick_i,
  input wire logic [15:0] timeout_i,
  // Expiry
  output logic expire_o
);
  initial if (TICK_CYC < 1) $error("TICK_CYC must be positive");
  logic [31:0] pre_q, pre_d;
  logic [15:0] cnt_q, cnt_d;
  logic exp_q, exp_d;
  // Millisecond prescaler and down counter, gated by run
  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (!run_i || kick_i) begin
      pre_d = '0;
      cnt_d = timeout_i;
    end else if (pre_q == 32'(TICK_CYC - 1)) begin
      pre_d = '0;
      if (cnt_q <= 16'h0001) begin
        exp_d = 1'b1;
        cnt_d = timeout_i;
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
    end else begin
      pre_d = pre_q + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_q <= '0;
      cnt_q <= `SPMC_WDT_TO_RST;
      exp_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end
  assign expire_o = exp_q;
endmodule

// *** core/spmc_sync.sv ***
`timescale 1ns/100ps
module spmc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  initial if (W < 1) $error("W must be positive");
  logic [W-1:0] s1_q, s2_q;
  // Two-stage synchroniser
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule

// *** core/spmc_top.sv ***
`timescale 1ns/100ps
`include "spmc_params.svh"
module spmc_top
  import spmc_pkg::*;
#(
  parameter int N_SUP = 3,
  parameter int MEM_WORDS = 32,
  parameter int TICK_CYC = `SPMC_TICK_NS / `SPMC_CLK_NS
) (
  // Clock and power-on reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Supply monitors and wake pin
  input wire logic [N_SUP-1:0] sup_good_i,
  input wire logic wake_pin_i,
  // Real-time counter
  input wire logic [63:0] rtc_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Chip control
  output logic chip_rst_b_o,
  output logic core_pwr_en_o,
  output logic asleep_o,
  output logic awake_o
);
  // Parameter checks: the word index and supply vector have fixed uses
  initial begin
    if (N_SUP < 1) begin
      $error("N_SUP must be at least one");
    end
    if (MEM_WORDS != 32) begin
      $error("MEM_WORDS must match the 5-bit word index");
    end
    if (TICK_CYC < 1) begin
      $error("TICK_CYC must be positive");
    end
  end

  logic [N_SUP-1:0] sup_s;
  logic pin_s, pin_prev_q, pin_prev_d;
  logic wdt_exp;
  spmc_state_t st_q, st_d;
  logic [4:0] step_q, step_d;
  logic chip_rst_q, chip_rst_d;
  logic wdt_en_q, wdt_en_d;
  logic [15:0] wdt_to_q, wdt_to_d;
  logic [2:0] wcfg_q, wcfg_d;
  logic [63:0] cmp_q, cmp_d;
  logic wake_pend_q, wake_pend_d;
  logic rc_wdt_q, rc_wdt_d;
  logic rc_por_q, rc_por_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] mem_q [MEM_WORDS];
  logic all_good, sleep_req, kick, pin_evt, tmr_evt, wake_evt, wdt_rst;
  logic pwr_q, pwr_d, slp_q, slp_d, run_q, run_d;

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Last cycle of a fixed-length transition
  function automatic logic step_last(input logic [4:0] s);
    return s == 5'(`SPMC_STEP_CYC);
  endfunction

  // Next transition step count
  function automatic logic [4:0] step_next(input logic [4:0] s);
    return s + 5'd1;
  endfunction

  // Supplies and pin come from outside the clock domain
  spmc_sync #(.W(N_SUP)) u_sup_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .d_i(sup_good_i),
    .q_o(sup_s)
  );
  spmc_sync #(.W(1)) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .d_i(wake_pin_i),
    .q_o(pin_s)
  );

  // Watchdog runs only in the awake state and when enabled
  spmc_wdt #(.TICK_CYC(TICK_CYC)) u_wdt (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .run_i(st_q == SPMC_AWAKE && wdt_en_q),
    .kick_i(kick),
    .timeout_i(wdt_to_q),
    .expire_o(wdt_exp)
  );

  // Bus decode and wake events
  always_comb begin
    all_good = &sup_s;
    sleep_req = wr_i && hit(addr_i, `SPMC_A_CTRL)
      && wdata_i[`SPMC_CTRL_SLEEP];
    kick = wr_i && hit(addr_i, `SPMC_A_WDT_KICK);
    // Pin wake on the edge that software selected
    pin_evt = wcfg_q[`SPMC_WCFG_PIN_EN] && (pin_s != pin_prev_q)
      && (pin_s == wcfg_q[`SPMC_WCFG_PIN_POL]);
    tmr_evt = wcfg_q[`SPMC_WCFG_TMR_EN] && (rtc_i >= cmp_q);
    wake_evt = pin_evt || tmr_evt;
    // Expiry resets the chip only while running with supplies good
    wdt_rst = (st_q == SPMC_AWAKE) && wdt_exp && all_good;
  end

  // Previous synchronised pin level for edge detection
  always_comb begin
    pin_prev_d = pin_s;
  end

  // Resets low like the synchroniser, so reset shows no edge
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_prev_d;
    end
  end

  // Power mode sequencer
  always_comb begin
    st_d = st_q;
    step_d = step_q;
    chip_rst_d = chip_rst_q;
    wake_pend_d = wake_pend_q;
    unique case (st_q)
      // Hold the chip until supplies settle, then release it
      SPMC_PWRUP: begin
        chip_rst_d = 1'b1;
        wake_pend_d = 1'b0;
        if (!all_good) begin
          step_d = '0;
        end else if (step_last(step_q)) begin
          st_d = SPMC_AWAKE;
          chip_rst_d = 1'b0;
          step_d = '0;
        end else begin
          step_d = step_next(step_q);
        end
      end
      // Running; wake stimuli are ignored here
      SPMC_AWAKE: begin
        if (!all_good) begin
          st_d = SPMC_PWRUP;
          chip_rst_d = 1'b1;
          step_d = '0;
        end else if (wdt_rst) begin
          st_d = SPMC_PWRUP;
          chip_rst_d = 1'b1;
          step_d = '0;
        end else if (sleep_req) begin
          st_d = SPMC_GO_SLEEP;
          step_d = '0;
        end
      end
      // Sleep entry; a wake seen here waits for the asleep state
      SPMC_GO_SLEEP: begin
        if (wake_evt) wake_pend_d = 1'b1;
        if (!all_good) begin
          st_d = SPMC_PWRUP;
          chip_rst_d = 1'b1;
          step_d = '0;
        end else if (step_last(step_q)) begin
          st_d = SPMC_ASLEEP;
          chip_rst_d = 1'b1;
          step_d = '0;
        end else begin
          step_d = step_next(step_q);
        end
      end
      // Quiescent until a wake event or a held wake
      SPMC_ASLEEP: begin
        if (!all_good) begin
          st_d = SPMC_PWRUP;
          chip_rst_d = 1'b1;
          step_d = '0;
        end else if (wake_evt || wake_pend_q) begin
          st_d = SPMC_GO_WAKE;
          wake_pend_d = 1'b0;
          step_d = '0;
        end
      end
      // Wake transition; the chip is released at its end
      SPMC_GO_WAKE: begin
        if (!all_good) begin
          st_d = SPMC_PWRUP;
          chip_rst_d = 1'b1;
          step_d = '0;
        end else if (step_last(step_q)) begin
          st_d = SPMC_AWAKE;
          chip_rst_d = 1'b0;
          step_d = '0;
        end else begin
          step_d = step_next(step_q);
        end
      end
      // Unused codes restart the power-up sequence
      default: begin
        st_d = SPMC_PWRUP;
        chip_rst_d = 1'b1;
        step_d = '0;
      end
    endcase
  end

  // A short supply dip restarts the power-up count from zero
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= SPMC_PWRUP;
      step_q <= '0;
      chip_rst_q <= 1'b1;
      wake_pend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      step_q <= step_d;
      chip_rst_q <= chip_rst_d;
      wake_pend_q <= wake_pend_d;
    end
  end

  // Reset cause: software clears by writing ones, a new cause wins
  always_comb begin
    rc_wdt_d = rc_wdt_q;
    rc_por_d = rc_por_q;
    if (wr_i && hit(addr_i, `SPMC_A_RSTCAUSE)) begin
      if (wdata_i[`SPMC_RC_POR]) rc_por_d = 1'b0;
      if (wdata_i[`SPMC_RC_WDT]) rc_wdt_d = 1'b0;
    end
    if (wdt_rst) rc_wdt_d = 1'b1;
  end

  // Kept across supervisor resets; only power-on sets that cause
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rc_wdt_q <= 1'b0;
      rc_por_q <= 1'b1;
    end else begin
      rc_wdt_q <= rc_wdt_d;
      rc_por_q <= rc_por_d;
    end
  end

  // Status outputs follow the next state, so they leave flip-flops
  always_comb begin
    pwr_d = (st_d != SPMC_ASLEEP);
    slp_d = (st_d == SPMC_ASLEEP);
    run_d = (st_d == SPMC_AWAKE);
  end

  // Reset values match the power-up state
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwr_q <= 1'b1;
      slp_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      slp_q <= slp_d;
      run_q <= run_d;
    end
  end

  // Configuration registers
  always_comb begin
    wdt_en_d = wdt_en_q;
    wdt_to_d = wdt_to_q;
    wcfg_d = wcfg_q;
    cmp_d = cmp_q;
    if (wr_i) begin
      if (hit(addr_i, `SPMC_A_CTRL)) wdt_en_d = wdata_i[`SPMC_CTRL_WDT_EN];
      if (hit(addr_i, `SPMC_A_WDT_TO)) begin
        // Zero is raised to the one-millisecond floor
        wdt_to_d = (wdata_i[15:0] == 16'h0000) ? 16'h0001
          : wdata_i[15:0];
      end
      if (hit(addr_i, `SPMC_A_WAKE_CFG)) wcfg_d = wdata_i[2:0];
      if (hit(addr_i, `SPMC_A_CMP_LO)) cmp_d[31:0] = wdata_i;
      if (hit(addr_i, `SPMC_A_CMP_HI)) cmp_d[63:32] = wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdt_en_q <= 1'b0;
      wdt_to_q <= `SPMC_WDT_TO_RST;
      wcfg_q <= '0;
      cmp_q <= '0;
    end else begin
      wdt_en_q <= wdt_en_d;
      wdt_to_q <= wdt_to_d;
      wcfg_q <= wcfg_d;
      cmp_q <= cmp_d;
    end
  end

  // Deep sleep memory: kept across sleep and chip reset
  always_ff @(posedge clk_sys_i) begin
    if (wr_i && addr_i[7]) begin
      mem_q[addr_i[6:2]] <= wdata_i;
    end
  end

  // Read mux, data in the following cycle
  always_comb begin
    rdata_d = '0;
    if (rd_i) begin
      if (addr_i[7]) begin
        rdata_d = mem_q[addr_i[6:2]];
      end else begin
        unique case (addr_i)
          `SPMC_A_CTRL: rdata_d = {30'h0, wdt_en_q, 1'b0};
          `SPMC_A_STAT: rdata_d = {27'h0, wake_pend_q, 1'b0, st_q};
          `SPMC_A_WDT_TO: rdata_d = {16'h0, wdt_to_q};
          `SPMC_A_WAKE_CFG: rdata_d = {29'h0, wcfg_q};
          `SPMC_A_CMP_LO: rdata_d = cmp_q[31:0];
          `SPMC_A_CMP_HI: rdata_d = cmp_q[63:32];
          `SPMC_A_CNT_LO: rdata_d = rtc_i[31:0];
          `SPMC_A_CNT_HI: rdata_d = rtc_i[63:32];
          `SPMC_A_RSTCAUSE: rdata_d = {30'h0, rc_por_q, rc_wdt_q};
          default: rdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) rdata_q <= '0;
    else rdata_q <= rdata_d;
  end

  // Outputs
  assign rdata_o = rdata_q;
  assign chip_rst_b_o = !chip_rst_q;
  assign core_pwr_en_o = pwr_q;
  assign asleep_o = slp_q;
  assign awake_o = run_q;
endmodule

// *** dv/spmc_top_chk.sv ***
`timescale 1ns/100ps
module spmc_top_chk #(
  parameter int N_SUP = 3
) (
  // Clock, reset and supplies
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [N_SUP-1:0] sup_good_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Chip control
  input wire logic chip_rst_b_o,
  input wire logic core_pwr_en_o,
  input wire logic asleep_o,
  input wire logic awake_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // Chip held in reset shortly after any supply is bad
  chk_sup_hold: assert property (
    !(&$past(sup_good_i, 4)) |-> !chip_rst_b_o)
    else $error("chip released with bad supply");
  // Reset only lifts into the running state
  chk_rst_awake: assert property (
    $rose(chip_rst_b_o) |-> awake_o)
    else $error("reset lifted outside running");
  // Sleep is powered down and held in reset
  chk_asleep_off: assert property (
    asleep_o |-> !core_pwr_en_o && !chip_rst_b_o)
    else $error("core powered while asleep");
  // Core power returns only while the chip is still held in reset
  chk_pwr_on: assert property (
    $rose(core_pwr_en_o) |-> !chip_rst_b_o)
    else $error("core powered up out of reset");
  // Sleep request walks through the entry transition
  chk_sleep_entry: assert property (
    wr_i && addr_i == 8'h00 && wdata_i[0] && awake_o
    |=> (!awake_o && !asleep_o) ##[15:18] asleep_o)
    else $error("sleep entry wrong");
  // Leaving sleep ends in running after the wake transition
  chk_wake_seq: assert property (
    $fell(asleep_o) |-> ##[15:22] awake_o)
    else $error("wake transition wrong");
  // Read data is zero outside the answer cycle
  chk_rd_idle: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data not idle");
  // State code reads as running while awake
  chk_stat_run: assert property (
    rd_i && !wr_i && addr_i == 8'h04 && awake_o
    |=> rdata_o[2:0] == 3'h1)
    else $error("state code wrong");
endmodule

// *** dv/spmc_sup_model.sv ***
`timescale 1ns/100ps
module spmc_sup_model (
  // Clock and commands
  input wire logic clk_i,
  input wire logic drop_i,
  input wire logic pin_i,
  // Monitor outputs
  output logic [2:0] sup_good_o,
  output logic wake_pin_o
);
  int cnt = 0;
  // Supplies come good one by one; a drop pulls all low
  always @(posedge clk_i) begin
    if (drop_i) begin
      cnt <= 0;
    end else if (cnt < 30) begin
      cnt <= cnt + 1;
    end
  end
  assign sup_good_o = {cnt > 24, cnt > 16, cnt > 8};
  assign wake_pin_o = pin_i;
endmodule

// *** dv/spmc_top_tb.sv ***
`timescale 1ns/100ps
module spmc_top_tb;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic drop = 1'b0;
  logic pin = 1'b0;
  logic [2:0] sup_good;
  logic wake_pin;
  logic [63:0] rtc = '0;
  logic [63:0] cmp_v;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] rdata;
  logic [31:0] dsm;
  logic chip_rst_b;
  logic pwr_en;
  logic asleep;
  logic awake;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int compares = 0;
  // Clock and free-running counter
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) rtc <= rtc + 64'h1;
  spmc_sup_model i_sup (.clk_i(clk_sys_i), .drop_i(drop), .pin_i(pin),
    .sup_good_o(sup_good), .wake_pin_o(wake_pin));
  spmc_top #(.TICK_CYC(10)) i_dut (.clk_sys_i, .rst_b_i,
    .sup_good_i(sup_good), .wake_pin_i(wake_pin), .rtc_i(rtc),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .chip_rst_b_o(chip_rst_b), .core_pwr_en_o(pwr_en), .asleep_o(asleep),
    .awake_o(awake));
  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
  endtask
  // Wait for running (0), asleep (1) or chip reset (2)
  task automatic wait_on(input int k, input int lim);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    while (!((k == 0 && awake === 1'b1) || (k == 1 && asleep === 1'b1)
             || (k == 2 && chip_rst_b === 1'b0))) begin
      @(negedge clk_sys_i);
      n++;
      if (n > lim) begin
        err_total++;
        $display("CHECK FAILED wait %0d exp 1 got 0", k);
        print_verdict();
      end
    end
  endtask
  // Read answers checked against the oldest note
  always @(posedge clk_sys_i) rd_d <= rd;
  always @(negedge clk_sys_i) begin
    if (rd_d) begin
      cmp("rdata", exp_q.pop_front(), rdata);
    end
  end
  // Main sequence; sleep is only requested while running
  initial begin
    void'($urandom(51));
    dsm = $urandom();
    repeat (6) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    wait_on(0, 200);
    rd_reg(8'h24, 32'h0000_0002);
    rd_reg(8'h04, 32'h0000_0001);
    rd_reg(8'h08, 32'h0000_FFFF);
    rd_reg(8'h28, 32'h0000_0000);
    wr_reg(8'h24, 32'h0000_0003);
    rd_reg(8'h24, 32'h0000_0000);
    wr_reg(8'h80, dsm);
    // Rising pin during sleep entry is held until asleep
    wr_reg(8'h10, 32'h0000_0003);
    wr_reg(8'h00, 32'h0000_0001);
    repeat (3) @(posedge clk_sys_i);
    pin <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd_reg(8'h04, 32'h0000_0012);
    wait_on(1, 40);
    wait_on(0, 40);
    rd_reg(8'h80, dsm);
    // Falling pin wakes; until then the chip stays asleep
    wr_reg(8'h10, 32'h0000_0001);
    wr_reg(8'h00, 32'h0000_0001);
    wait_on(1, 40);
    repeat (20) @(negedge clk_sys_i);
    cmp("asleep", 32'h0000_0001, {31'h0, asleep});
    cmp("pwr_en", 32'h0000_0000, {31'h0, pwr_en});
    @(posedge clk_sys_i);
    pin <= 1'b0;
    wait_on(0, 40);
    // A pin edge while running must not wake the next sleep early
    @(posedge clk_sys_i);
    pin <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    pin <= 1'b0;
    // Counter match wakes, not before the compare value
    cmp_v = rtc + 64'h12C + 64'($urandom() % 100);
    wr_reg(8'h14, cmp_v[31:0]);
    wr_reg(8'h18, cmp_v[63:32]);
    rd_reg(8'h18, cmp_v[63:32]);
    wr_reg(8'h10, 32'h0000_0004);
    wr_reg(8'h00, 32'h0000_0001);
    wait_on(1, 40);
    wait_on(0, 600);
    cmp("late", 32'h0000_0001, {31'h0, rtc >= cmp_v + 64'h11});
    // Supply loss while running, then restart
    drop <= 1'b1;
    wait_on(2, 10);
    repeat (5) @(posedge clk_sys_i);
    drop <= 1'b0;
    wait_on(0, 200);
    // Watchdog serviced in time, then left to expire
    wr_reg(8'h08, 32'h0000_0003);
    wr_reg(8'h00, 32'h0000_0002);
    repeat (4) begin
      repeat (10) @(posedge clk_sys_i);
      wr_reg(8'h0C, $urandom());
    end
    @(negedge clk_sys_i);
    cmp("chip_rst", 32'h0000_0001, {31'h0, chip_rst_b});
    wait_on(2, 60);
    wait_on(0, 200);
    rd_reg(8'h24, 32'h0000_0001);
    wr_reg(8'h00, 32'h0000_0000);
    repeat (3) @(posedge clk_sys_i);
    print_verdict();
  end
endmodule
bind spmc_top spmc_top_chk #(.N_SUP(N_SUP)) i_chk (.clk_sys_i, .rst_b_i,
  .sup_good_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .chip_rst_b_o,
  .core_pwr_en_o, .asleep_o, .awake_o);
